// [verilog/srxlos_top.sv]
// Purpose: Receive path with alignment, 8b/10b decode, signal-loss tracking
// Assumes: One core clock; raw 10-bit groups arrive with a valid strobe
// Notes: Code bit 9 is the first bit on the line (a), bit 0 the last (j)
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "srxlos_map.svh"

// Operation
// [RULE1] Tx powered down or Tx PLL unlocked holds serial legs at bias.
// [RULE2] Invalid control char sends K30.7 in 8-bit mode, raw word in 10-bit.
// [RULE3] Equalizer pins 00 use management setting, else pins pick strength.
// [RULE4] One output word per receive clock edge, two per period.
// [RULE5] 10-bit mode outputs code; 8-bit mode data, D/K flag, error flag.
// [RULE6] 10-bit unlocked: clock from reference, output bus all ones.
// [RULE7] 10-bit locked: recovered clock and words; system clock follows it.
// [RULE8] Write mode drives receive clock; outputs change with it.
// [RULE9] Read mode takes receive clock as strobe launching outputs.
// [RULE10] Read-mode strobe must be synchronous to the serial stream.
// [RULE11] Outside logic holds clocks static while synchronizing.
// [RULE12] Active-low lock indicator high when unlocked, low when locked.
// [RULE13] Decoder takes valid data and twelve controls; invalid becomes K30.7.
// [RULE14] Alignment enabled: realign on K28.1, K28.5 or K28.7 commas.
// [RULE15] Comma flag stands for exactly one output word.
// [RULE16] Alignment disabled: commas still flagged, boundary kept.
// [RULE17] Signal loss forced high at power-up, pin reset and soft reset.
// [RULE18] Signal loss falls after K28.5 then one clean hyperframe.
// [RULE19] Sixteen violations in a hyperframe set loss; clean one clears it.
// [RULE20] Lock loss alone never raises signal loss.
// [RULE21] 8-bit mode: outputs static until signal loss first falls.
// [RULE22] 8-bit mode: 2-3 hyperframes grace, then tri-state and reset.
// [RULE23] 10-bit mode: loss detection off, flag held high.
// [RULE24] Violation counter restarts at each hyperframe boundary.
module srxlos_top
   import srxlos_pkg::*;
(
   input wire logic core_clk_i, // Core clock, 25 MHz
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic [3:0] reg_addr_i, // Register word address
   input wire logic [15:0] reg_wdata_i, // Register write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [15:0] reg_rdata_o, // Read data, cycle after strobe
   input wire logic tx_power_down_n_i, // Tx powered when high
   input wire logic tx_pll_locked_i, // Tx PLL lock
   input wire logic [9:0] tx_word_i, // Tx parallel word
   output srxlos_line_t serial_out_pair_o, // Serial line state
   input wire logic ten_bit_mode_sel_i, // 1 = 10-bit mode
   input wire logic rx_power_down_n_i, // Rx powered when high
   input wire logic reset_n_pin_i, // Logic reset pin, active low
   input wire logic rx_pll_locked_i, // Rx PLL lock
   input wire logic [9:0] rx_bits_i, // Raw deserialized bits
   input wire logic rx_bits_valid_i, // Raw group valid
   input wire logic ref_tick_i, // Reference clock edge tick
   input wire logic [1:0] eq_strength_sel_i, // Equalizer pins
   output logic [1:0] eq_strength_o, // Equalizer strength in use
   input wire logic comma_align_enable_i, // Comma alignment enable
   input wire logic rx_clock_dir_sel_i, // 0 write mode, 1 read mode
   input wire logic rx_word_clock_i, // Receive clock pin, input side
   output logic rx_word_clock_o, // Receive clock pin, output side
   output logic rx_word_clock_oe_o, // Receive clock drive enable
   output logic [9:0] rx_parallel_out_o, // Output bus
   output logic rx_out_oe_o, // Output bus drive enable
   output srxlos_stat_t rx_status_o, // Comma, unlocked, loss
   output logic sync_clock_src_o // 1 = system clock from recovered
);

   ////////////////////////////////////////////////////////////////////////////
   // Code tables, rd- forms
   localparam logic [5:0] T6 [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] T4 [8] = '{
      4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

   // Controls the decoder and transmitter accept
   function automatic logic srx_k_ok(input logic [7:0] b);
      srx_k_ok = (b[4:0] == 5'h1c) || (b == 8'hf7) || (b == 8'hfb) ||
                 (b == 8'hfd) || (b == `SRX_K307);
   endfunction : srx_k_ok

   // Either disparity accepted; balanced forms only where they are genuine
   function automatic srxlos_dec_t srx_decode(input logic [9:0] cw);
      logic [5:0] s6;
      logic [3:0] s4;
      logic f6;
      logic f4;
      logic k28;
      logic alt7;
      logic [4:0] x;
      logic [2:0] y;
      srxlos_dec_t r;
      s6 = cw[9:4];
      s4 = cw[3:0];
      f6 = 1'b0;
      f4 = 1'b0;
      x = 5'h00;
      y = 3'h0;
      for (int i = 0; i < 32; i++) begin
         if (s6 == T6[i] ||
             (s6 == ~T6[i] && ($countones(T6[i]) != 3 || i == 7))) begin
            f6 = 1'b1;
            x = i[4:0];
         end
      end
      for (int i = 0; i < 8; i++) begin
         if (s4 == T4[i] ||
             (s4 == ~T4[i] && ($countones(T4[i]) != 2 || i == 3))) begin
            f4 = 1'b1;
            y = i[2:0];
         end
      end
      k28 = (s6 == 6'h0f) || (s6 == 6'h30);
      alt7 = (s4 == 4'h7) || (s4 == 4'h8);
      if (k28) begin
         x = 5'h1c;
      end
      if (alt7) begin
         y = 3'h7;
      end
      r.data = {y, x};
      r.k = k28 || (alt7 && (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e));
      r.line_code_violation = !((f6 || k28) && (f4 || alt7)) || (r.k && !srx_k_ok(r.data));
      if (r.line_code_violation) begin
         r.k = 1'b1; // [RULE13]
         r.data = `SRX_K307;
      end
      srx_decode = r;
   endfunction : srx_decode

   // Comma sits in the first seven bits of a group
   function automatic logic srx_has_comma(input logic [9:0] cw);
      srx_has_comma = (cw[9:3] == `SRX_COMMA_POS) || (cw[9:3] == `SRX_COMMA_NEG);
   endfunction : srx_has_comma

   ////////////////////////////////////////////////////////////////////////////
   // Shared signals
   logic lrst;
   logic soft_rst_r;
   logic [1:0] eq_mgmt_r;
   logic [15:0] hf_len_r;
   logic [9:0] prev_bits_r;
   logic [3:0] off_r;
   logic [3:0] off_nxt;
   logic [19:0] cat;
   logic [9:0] cw_now;
   logic [9:0] cw_r;
   srxlos_dec_t dec_r;
   logic comma_r;
   logic dec_valid_r;
   logic [15:0] hf_cnt_r;
   logic [4:0] lcv_cnt_r;
   logic hf_close;
   logic sohf;
   srxlos_state_t los_st_r;
   logic [1:0] grace_r;
   logic los_r;
   logic started_r;
   logic tristate_r;
   logic strobe_q_r;
   logic launch;
   logic [9:0] out_r;
   logic clk_r;
   srxlos_stat_t stat_r;

   // Pin, soft and power-down resets all restart the receive logic
   assign lrst = rst_i || !reset_n_pin_i || soft_rst_r || !rx_power_down_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         soft_rst_r <= 1'b0;
         eq_mgmt_r <= `SRX_CTRL_RST;
         hf_len_r <= `SRX_HFLEN_RST;
      end else begin
         soft_rst_r <= reg_wr_i && reg_addr_i == `SRX_REG_CTRL &&
                       reg_wdata_i[`SRX_CTRL_SRST]; // [RULE17]
         if (reg_wr_i && reg_addr_i == `SRX_REG_CTRL) begin
            eq_mgmt_r <= reg_wdata_i[`SRX_CTRL_EQ_HI:`SRX_CTRL_EQ_LO];
         end
         if (reg_wr_i && reg_addr_i == `SRX_REG_HFLEN) begin
            hf_len_r <= reg_wdata_i;
         end
      end
   end

   // Read data for one cycle only; unmapped reads return zero
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         case (reg_addr_i)
            `SRX_REG_CTRL: reg_rdata_o <= {13'h0000, eq_mgmt_r, 1'b0};
            `SRX_REG_HFLEN: reg_rdata_o <= hf_len_r;
            `SRX_REG_STAT: reg_rdata_o <= {3'h0, lcv_cnt_r, off_r, started_r,
                                           tristate_r, !rx_pll_locked_i, los_r};
            default: reg_rdata_o <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit line state and front-end settings
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !tx_power_down_n_i || !tx_pll_locked_i) begin
         serial_out_pair_o <= '{bias: 1'b1, word: 10'h000}; // [RULE1]
      end else if (!ten_bit_mode_sel_i && tx_word_i[8] && !srx_k_ok(tx_word_i[7:0])) begin
         serial_out_pair_o <= '{bias: 1'b0, word: {2'h1, `SRX_K307}}; // [RULE2]
      end else begin
         serial_out_pair_o <= '{bias: 1'b0, word: tx_word_i}; // [RULE2]
      end
   end

   // Pins win unless both are low
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         eq_strength_o <= 2'h0;
         sync_clock_src_o <= 1'b0;
      end else begin
         eq_strength_o <= (eq_strength_sel_i == 2'h0) ? eq_mgmt_r : eq_strength_sel_i; // [RULE3]
         sync_clock_src_o <= rx_pll_locked_i; // [RULE7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comma search over the last two groups; window k borrows k bits from
   // the previous group, so an aligned stream decodes with no group of lag
   assign cat = {prev_bits_r, rx_bits_i};

   always_comb begin
      off_nxt = off_r;
      for (int k = 9; k >= 0; k--) begin
         if (comma_align_enable_i && srx_has_comma(cat[9+k -: 10])) begin
            off_nxt = k[3:0]; // [RULE14]
         end
      end
      cw_now = cat[9+off_nxt -: 10];
   end

   // Boundary moves only with alignment enabled; flagging never stops
   always_ff @(posedge core_clk_i) begin
      if (lrst) begin
         prev_bits_r <= 10'h000;
         off_r <= 4'h0;
         cw_r <= 10'h000;
         dec_r <= '0;
         comma_r <= 1'b0;
         dec_valid_r <= 1'b0;
      end else begin
         dec_valid_r <= rx_bits_valid_i;
         if (rx_bits_valid_i) begin
            prev_bits_r <= rx_bits_i;
            off_r <= off_nxt; // [RULE16]
            cw_r <= cw_now;
            dec_r <= srx_decode(cw_now); // [RULE13]
            comma_r <= srx_has_comma(cw_now); // [RULE16]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hyperframe boundary from start character or configured length
   assign sohf = dec_r.k && !dec_r.line_code_violation && dec_r.data == `SRX_SOHF;
   assign hf_close = dec_valid_r && (sohf || hf_cnt_r >= hf_len_r);

   always_ff @(posedge core_clk_i) begin
      if (lrst) begin
         hf_cnt_r <= 16'h0000;
         lcv_cnt_r <= 5'h00;
      end else if (hf_close) begin
         hf_cnt_r <= 16'h0001; // [RULE24]
         lcv_cnt_r <= {4'h0, dec_r.line_code_violation}; // [RULE24]
      end else if (dec_valid_r) begin
         hf_cnt_r <= hf_cnt_r + 16'h0001;
         if (dec_r.line_code_violation && lcv_cnt_r != 5'h1f) begin
            lcv_cnt_r <= lcv_cnt_r + 5'h01;
         end
      end
   end

   // Loss tracking; PLL lock deliberately plays no part here
   always_ff @(posedge core_clk_i) begin
      if (lrst || ten_bit_mode_sel_i) begin
         los_st_r <= LOS_WAIT_SYNC; // [RULE23]
         grace_r <= 2'h0;
      end else begin
         case (los_st_r)
            LOS_WAIT_SYNC: begin
               if (dec_valid_r && sohf) begin
                  los_st_r <= LOS_QUALIFY; // [RULE18]
               end
            end
            LOS_QUALIFY: begin
               if (hf_close) begin
                  los_st_r <= (lcv_cnt_r == 5'h00) ? LOS_CLEAR : LOS_WAIT_SYNC; // [RULE18]
               end
            end
            LOS_CLEAR: begin
               if (hf_close && lcv_cnt_r >= `SRX_LCV_LIMIT) begin
                  los_st_r <= LOS_GRACE; // [RULE19] [RULE20]
                  grace_r <= 2'h0;
               end
            end
            LOS_GRACE: begin
               if (hf_close && lcv_cnt_r == 5'h00) begin
                  los_st_r <= LOS_CLEAR; // [RULE19] [RULE22]
               end else if (hf_close && grace_r + 2'h1 >= `SRX_GRACE_HF) begin
                  los_st_r <= LOS_DEAD; // [RULE22]
               end else if (hf_close) begin
                  grace_r <= grace_r + 2'h1;
               end
            end
            LOS_DEAD: los_st_r <= LOS_WAIT_SYNC;
            default: los_st_r <= LOS_WAIT_SYNC;
         endcase
      end
   end

   // Flag, first-start latch and tri-state after a failed grace period
   always_ff @(posedge core_clk_i) begin
      if (lrst) begin
         los_r <= 1'b1; // [RULE17]
         started_r <= 1'b0;
         tristate_r <= 1'b0;
      end else begin
         los_r <= ten_bit_mode_sel_i || los_st_r != LOS_CLEAR; // [RULE23]
         if (los_st_r == LOS_DEAD) begin
            started_r <= 1'b0; // [RULE22]
            tristate_r <= 1'b1;
         end else if (!los_r) begin
            started_r <= 1'b1; // [RULE21]
            tristate_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Launch: each decoded word in write mode, each strobe edge in read mode
   assign launch = rx_clock_dir_sel_i ? (strobe_q_r != rx_word_clock_i) : dec_valid_r; // [RULE9] [RULE10]

   always_ff @(posedge core_clk_i) begin
      if (lrst) begin
         strobe_q_r <= 1'b0;
      end else begin
         strobe_q_r <= rx_word_clock_i;
      end
   end

   // Every clock edge carries one word, so a toggle marks each word
   always_ff @(posedge core_clk_i) begin
      if (lrst) begin
         out_r <= 10'h000;
         clk_r <= 1'b0;
         stat_r <= '{comma: 1'b0, unlocked: 1'b1, signal_loss_flag: 1'b1};
      end else if (ten_bit_mode_sel_i && !rx_pll_locked_i) begin
         out_r <= `SRX_ALL_ONES; // [RULE6]
         clk_r <= ref_tick_i ? !clk_r : clk_r; // [RULE6]
         stat_r <= '{comma: 1'b0, unlocked: 1'b1, signal_loss_flag: 1'b1};
      end else begin
         if (launch && (ten_bit_mode_sel_i || started_r)) begin
            out_r <= ten_bit_mode_sel_i ? cw_r : dec_r; // [RULE5] [RULE7] [RULE21]
            clk_r <= !clk_r; // [RULE4] [RULE8]
            stat_r.comma <= comma_r; // [RULE15]
         end
         if (launch || !rx_clock_dir_sel_i) begin
            stat_r.unlocked <= !rx_pll_locked_i; // [RULE12] [RULE8]
            stat_r.signal_loss_flag <= los_r;
         end
      end
   end

   // Bus and clock pins go quiet when powered down or tri-stated
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_out_oe_o <= 1'b0;
         rx_word_clock_oe_o <= 1'b0;
      end else begin
         rx_out_oe_o <= rx_power_down_n_i && !tristate_r; // [RULE22]
         rx_word_clock_oe_o <= rx_power_down_n_i && !tristate_r && !rx_clock_dir_sel_i; // [RULE8]
      end
   end

   assign rx_parallel_out_o = out_r;
   assign rx_word_clock_o = clk_r;
   assign rx_status_o = stat_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_TX_BIAS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1
      (!tx_power_down_n_i || !tx_pll_locked_i) |=> serial_out_pair_o.bias)
      else $error("serial line not at bias");
   AST_TX_K307: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE2
      (tx_power_down_n_i && tx_pll_locked_i && !ten_bit_mode_sel_i && tx_word_i[8] &&
       !srx_k_ok(tx_word_i[7:0])) |=> serial_out_pair_o.word[7:0] == `SRX_K307)
      else $error("invalid control not replaced");
   AST_EQ_PIN: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE3
      eq_strength_sel_i != 2'h0 |=> eq_strength_o == $past(eq_strength_sel_i))
      else $error("equalizer pins ignored");
   AST_TEN_ONES: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE6
      (ten_bit_mode_sel_i && !rx_pll_locked_i) |=> rx_parallel_out_o == `SRX_ALL_ONES)
      else $error("unlocked output not all ones");
   AST_LOCK_IND: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE12
      !rx_clock_dir_sel_i |=> rx_status_o.unlocked == !$past(rx_pll_locked_i))
      else $error("lock indicator wrong");
   AST_ALIGN_HOLD: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE16
      !comma_align_enable_i |=> $stable(off_r))
      else $error("boundary moved while alignment off");
   AST_COMMA_WORD: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE15
      (launch && started_r && !ten_bit_mode_sel_i) |=> rx_status_o.comma == $past(comma_r))
      else $error("comma flag not tied to its word");
   AST_LOS_RST: assert property (@(posedge core_clk_i) // RULE17
      lrst |=> los_r)
      else $error("loss flag not forced on reset");
   AST_LOS_SET: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE19
      (los_st_r == LOS_CLEAR && hf_close && lcv_cnt_r >= `SRX_LCV_LIMIT &&
       !ten_bit_mode_sel_i) |=> ##1 los_r)
      else $error("loss flag not set on violations");
   AST_LOCK_FREE: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE20
      (los_st_r == LOS_CLEAR && !hf_close && !ten_bit_mode_sel_i) |=> los_st_r == LOS_CLEAR)
      else $error("loss state left without a verdict");
   AST_STATIC: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE21
      (!ten_bit_mode_sel_i && !started_r) |=> $stable(rx_parallel_out_o))
      else $error("output moved before first start");
   AST_TEN_LOS: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE23
      ten_bit_mode_sel_i |=> los_r)
      else $error("loss flag low in 10-bit mode");
   AST_HF_RESTART: assert property (@(posedge core_clk_i) disable iff (lrst) // RULE24
      hf_close |=> (hf_cnt_r == 16'h0001 && lcv_cnt_r <= 5'h01))
      else $error("hyperframe counters not restarted");

endmodule : srxlos_top

// [include/srxlos_map.svh]
// Purpose: Register offsets, field positions, reset values and fixed codes
// Assumes: 4-bit word address, 16-bit register data
// Notes: Definitions only
`ifndef SRXLOS_MAP_SVH
`define SRXLOS_MAP_SVH

// Register offsets
`define SRX_REG_CTRL 4'h0
`define SRX_REG_HFLEN 4'h1
`define SRX_REG_STAT 4'h2

// Control register fields
`define SRX_CTRL_SRST 0
`define SRX_CTRL_EQ_LO 1
`define SRX_CTRL_EQ_HI 2

// Reset values
`define SRX_CTRL_RST 2'h0
`define SRX_HFLEN_RST 16'h1000

// Character codes and thresholds
`define SRX_K307 8'hfe
`define SRX_SOHF 8'hbc
`define SRX_COMMA_POS 7'h1f
`define SRX_COMMA_NEG 7'h60
`define SRX_LCV_LIMIT 5'h10
`define SRX_GRACE_HF 2'h2
`define SRX_ALL_ONES 10'h3ff

`endif

// [include/srxlos_pkg.sv]
// Purpose: Types shared by the receive path and its bench
// Assumes: Constants come from srxlos_map.svh
// Notes: Types only
package srxlos_pkg;

   // Serial output line state: bias forces both legs to the bias level
   typedef struct packed {
      logic bias;
      logic [9:0] word;
   } srxlos_line_t;

   // Decoded character, laid out as the 8-bit mode output bus
   typedef struct packed {
      logic line_code_violation;
      logic k;
      logic [7:0] data;
   } srxlos_dec_t;

   // Status pins; comma launched with the output bus, lock and loss refreshed every core cycle in write mode
   typedef struct packed {
      logic comma;
      logic unlocked;
      logic signal_loss_flag;
   } srxlos_stat_t;

   // Signal-loss tracking states
   typedef enum logic [2:0] {
      LOS_WAIT_SYNC = 3'b000,
      LOS_QUALIFY = 3'b001,
      LOS_CLEAR = 3'b010,
      LOS_GRACE = 3'b011,
      LOS_DEAD = 3'b100
   } srxlos_state_t;

endpackage : srxlos_pkg

// [verif/srxlos_framer.sv]
// Purpose: Framer-side model that drives the read-mode receive strobe
// Assumes: One strobe edge per request, timed by the core clock
// Notes: Mirrors the pin while the device drives it
`timescale 1ns/10ps
module srxlos_framer (
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Synchronous reset
   input wire logic follow_i, // Device drives the pin
   input wire logic level_i, // Resolved pin level
   input wire logic step_i, // Request one strobe edge
   output logic strobe_o // Strobe toward the device
);
   ////////////////////////////////////////
   // Static unless stepped or following the pin, so the receive buffer never slips
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_o <= 1'b0;
      end else if (follow_i) begin
         strobe_o <= level_i; // Avoids a false edge at hand-over
      end else if (step_i) begin
         strobe_o <= !strobe_o;
      end
   end
endmodule : srxlos_framer

// [verif/srxlos_top_bench.sv]
// Purpose: Self-checking bench for the receive path
// Assumes: Hyperframes close on the start character only
// Notes: Integer model predicts words, comma, clock and loss flag
`timescale 1ns/10ps
`include "srxlos_map.svh"
module srxlos_top_bench import srxlos_pkg::*; ;
   logic clk, rst, wr, rd, txpd, txlk, ten, rxpd, rpin, rxlk, vld, tick, cal, dir, step;
   logic pin, fstrb, wck, wcoe, poe, sclk;
   logic [1:0] eqs, eqo;
   logic [3:0] addr;
   logic [9:0] txw, bits, pout;
   logic [15:0] wdata, rdata;
   logic [31:0] seed;
   srxlos_line_t line;
   srxlos_stat_t stat;
   int fails, n_tests, cyc, lcv_m;
   bit los_m, sync_m, on_m;
   ////////////////////////////////////////
   srxlos_top srxlos_top_inst (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_power_down_n_i(txpd),
      .tx_pll_locked_i(txlk), .tx_word_i(txw), .serial_out_pair_o(line),
      .ten_bit_mode_sel_i(ten), .rx_power_down_n_i(rxpd), .reset_n_pin_i(rpin),
      .rx_pll_locked_i(rxlk), .rx_bits_i(bits), .rx_bits_valid_i(vld), .ref_tick_i(tick),
      .eq_strength_sel_i(eqs), .eq_strength_o(eqo), .comma_align_enable_i(cal),
      .rx_clock_dir_sel_i(dir), .rx_word_clock_i(pin), .rx_word_clock_o(wck),
      .rx_word_clock_oe_o(wcoe), .rx_parallel_out_o(pout), .rx_out_oe_o(poe),
      .rx_status_o(stat), .sync_clock_src_o(sclk));
   srxlos_framer srxlos_framer_inst (.clk_i(clk), .rst_i(rst), .follow_i(wcoe),
      .level_i(pin), .step_i(step), .strobe_o(fstrb));
   // Clock pin level from whoever drives it
   assign pin = wcoe ? wck : fstrb;
   // 25 MHz core clock
   always #20 clk = !clk;
   // Random reference ticks; hang guard
   always @(posedge clk) begin
      seed <= {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      tick <= seed[5];
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         close_out();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic chk_bit(input string w, input logic e, input logic g);
      chk(w, {15'h0000, e}, {15'h0000, g});
   endtask : chk_bit
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("register", e, rdata & m);
   endtask : reg_rd
   // Decoder model: anything unlisted is an invalid group
   function automatic logic [9:0] dec(input logic [9:0] c);
      case (c)
         10'h0fa: dec = 10'h1bc;
         10'h0f9: dec = 10'h13c;
         10'h0f8: dec = 10'h1fc;
         10'h2aa: dec = 10'h0b5;
         10'h155: dec = 10'h04a;
         default: dec = 10'h3fe;
      endcase
   endfunction : dec
   function automatic logic [9:0] rnd_d();
      rnd_d = seed[3] ? 10'h2aa : 10'h155;
   endfunction : rnd_d
   // One group through the line, compared with the model
   task automatic send(input logic [9:0] c);
      logic w0;
      w0 = wck;
      @(posedge clk);
      vld <= 1'b1;
      bits <= c;
      @(posedge clk);
      vld <= 1'b0;
      settle(2);
      if (ten) chk("word", rxlk ? {6'h00, c} : 16'h03ff, {6'h00, pout});
      else if (on_m) begin
         chk("word", {6'h00, dec(c)}, {6'h00, pout});
         chk_bit("comma", c[9:3] == `SRX_COMMA_POS, stat.comma);
         chk_bit("clock", !w0, wck);
      end else if (c != 10'h0fa) chk("frozen", 16'h0000, {6'h00, pout});
      if (!ten) begin
         lcv_m += int'(dec(c) == 10'h3fe);
         if (c == 10'h0fa) begin
            if (sync_m && lcv_m >= `SRX_LCV_LIMIT) los_m = 1'b1;
            if (sync_m && lcv_m == 0) los_m = 1'b0;
            sync_m = 1'b1;
            lcv_m = 0;
         end
         if (!los_m) on_m = 1'b1;
      end
      settle(3);
      chk_bit("los", ten | los_m, stat.signal_loss_flag);
      chk_bit("lock", !rxlk, stat.unlocked);
   endtask : send
   task automatic sync_up;
      send(10'h0fa);
      repeat (4) send(rnd_d());
      send(10'h0fa);
   endtask : sync_up
   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {clk, wr, rd, txpd, txlk, ten, rxlk, vld, cal, dir, step, eqs, addr, txw, bits} = '0;
      {wdata, fails, n_tests, cyc, lcv_m, sync_m, on_m} = '0;
      {rst, rxpd, rpin, los_m, tick} = 5'h1e;
      seed = 32'h350cab5a;
      settle(4);
      rst <= 1'b0;
      settle(2);
      chk("line", 16'h0400, {5'h00, line});
      reg_rd(`SRX_REG_STAT, 16'h0003, 16'h0003);
      reg_rd(`SRX_REG_HFLEN, 16'hffff, `SRX_HFLEN_RST);
      reg_wr(`SRX_REG_HFLEN, 16'h0064);
      reg_rd(`SRX_REG_HFLEN, 16'hffff, 16'h0064);
      reg_rd(4'h7, 16'hffff, 16'h0000);
      reg_wr(`SRX_REG_CTRL, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         eqs <= 2'(i);
         settle(3);
         chk("eq", (i == 0) ? 16'h0002 : 16'(i), {14'h0000, eqo});
      end
      @(posedge clk);
      txpd <= 1'b1;
      txw <= 10'h100;
      settle(3);
      chk("line", 16'h0400, {5'h00, line});
      txlk <= 1'b1;
      settle(3);
      chk("line", 16'h01fe, {5'h00, line});
      rxlk <= 1'b1;
      cal <= 1'b1;
      repeat (3) send(rnd_d());
      send(10'h0fa);
      repeat (8) send(rnd_d());
      send(10'h0fa);
      send(10'h0f9);
      send(rnd_d());
      send(10'h0f8);
      @(posedge clk);
      cal <= 1'b0;
      send(10'h0f9);
      send(rnd_d());
      @(posedge clk);
      cal <= 1'b1;
      send(10'h0fa);
      repeat (7) send(10'h000);
      @(posedge clk);
      rxlk <= 1'b0;
      repeat (8) send(10'h000);
      send(10'h0fa);
      @(posedge clk);
      rxlk <= 1'b1;
      repeat (16) send(10'h000);
      send(10'h0fa);
      repeat (3) send(rnd_d());
      send(10'h0fa);
      send(10'h2aa);
      @(posedge clk);
      dir <= 1'b1;
      vld <= 1'b1;
      bits <= 10'h155;
      @(posedge clk);
      vld <= 1'b0;
      settle(3);
      chk("held", 16'h00b5, {6'h00, pout});
      chk_bit("clkoe", 1'b0, wcoe);
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      settle(3);
      chk("strobed", 16'h004a, {6'h00, pout});
      dir <= 1'b0;
      for (int r = 0; r < 3; r++) begin
         sync_up();
         if (r == 0) reg_wr(`SRX_REG_CTRL, 16'h0005);
         else begin
            @(posedge clk);
            if (r == 1) rpin <= 1'b0;
            else rxpd <= 1'b0;
            @(posedge clk);
            {rpin, rxpd} <= 2'h3;
         end
         settle(3);
         chk_bit("los reset", 1'b1, stat.signal_loss_flag);
         {los_m, sync_m, on_m} = 3'h4;
      end
      @(posedge clk);
      ten <= 1'b1;
      rxlk <= 1'b0;
      send(10'h2aa);
      chk_bit("sync_system_clock", 1'b0, sclk);
      chk("line", 16'h0100, {5'h00, line});
      @(posedge clk);
      rxlk <= 1'b1;
      repeat (17) send(10'h000);
      send(10'h0fa);
      chk_bit("sync_system_clock", 1'b1, sclk);
      close_out();
   end
endmodule : srxlos_top_bench
